// ---- rtl/pss_supervision.sv ----
// System supervision registers: status, event latches, masks, protection and pin zero
// What this block does
// - thermal status bits follow threshold comparators live
// - converter status bits follow their conditions live
// - converter conditions set sticky event bits
// - thermal conditions set sticky event bits
// - each pin change sets its sticky event
// - write one clears event once source released
// - bit three masks thermal warning level interrupt
// - bit zero masks power-good level interrupt
// - strap loads level masks when enabled
// - overcurrent latch-off after 8us, 1ms, 3ms
// - latch-off shutdown raises an interrupt unless masked
// - optionally ignore overcurrent during voltage ramps
// - power-good forced bad or good during ramps
// - signed trim shifts oscillator by 160 kHz steps
// - data line low over 50ms resets serial logic
// - pin zero function field selects its role
// - drive bit picks open-drain or push-pull
`timescale 1ns/100ps
module pss_supervision #(
    parameter int LATCHOFF_MID_CYCLES = pss_pkg::LATCHOFF_MID_CYC,
    parameter int LATCHOFF_LONG_CYCLES = pss_pkg::LATCHOFF_LONG_CYC,
    parameter int BUS_STUCK_CYCLES = pss_pkg::BUS_STUCK_CYC,
    parameter int CNT_W = 21
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire pss_pkg::pss_cond_s cond_in,
    input wire logic [2:0] pin_in,
    input wire logic sda_in,
    input wire logic dynamic_voltage_ramp_in,
    input wire logic strap_load_enable_in,
    input wire logic [1:0] strap_pin_in,
    input wire pss_pkg::pss_req_s req_in,
    output logic [7:0] reg_rdata_out,
    output logic interrupt_out,
    output logic converter_shutdown_out,
    output logic serial_reset_out,
    output logic signed [2:0] oscillator_trim_out,
    output logic signed [10:0] oscillator_shift_khz_out,
    output logic pin0_out,
    output logic pin0_oe_out,
    output logic converter_enable_input_out,
    output logic voltage_select_input_out,
    output logic reload_input_out
);
    localparam int NSYNC = 10;

    // Three-stage synchronisers; a level counts only when stages two and three agree
    logic [NSYNC-1:0] sync1_ff, sync2_ff, sync3_ff, filt_ff;
    logic [NSYNC-1:0] raw_in;
    assign raw_in = {sda_in, pin_in, cond_in};

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            filt_ff <= '0;
        end else begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            for (int i = 0; i < NSYNC; i++) begin
                if (sync2_ff[i] == sync3_ff[i]) begin
                    filt_ff[i] <= sync3_ff[i];
                end
            end
        end
    end

    pss_pkg::pss_cond_s cond_f;
    logic [2:0] pin_f;
    logic sda_f;
    assign cond_f = filt_ff[5:0];
    assign pin_f = filt_ff[8:6];
    assign sda_f = filt_ff[9];

    // Software-visible registers
    logic [1:0] therm_evt_ff, therm_mask_ff;
    logic [3:0] conv_evt_ff, conv_mask_ff;
    logic [2:0] pin_evt_ff, pin_mask_ff;
    logic lvl_therm_mask_ff, lvl_pg_mask_ff;
    logic [1:0] shutdown_delay_ff, pg_override_ff;
    logic ramp_ignore_ff, bus_timeout_en_ff;
    logic [2:0] trim_ff;
    logic [3:0] pin0_func_ff;
    logic pin0_drive_ff;
    logic strap_done_ff;

    logic wr_hit_therm_evt, wr_hit_conv_evt, wr_hit_pin_evt;
    assign wr_hit_therm_evt = req_in.wr && req_in.addr == pss_pkg::ADDR_THERMAL_EVENTS;
    assign wr_hit_conv_evt = req_in.wr && req_in.addr == pss_pkg::ADDR_CONVERTER_EVENTS;
    assign wr_hit_pin_evt = req_in.wr && req_in.addr == pss_pkg::ADDR_PIN_EVENTS;

    // Ramp qualification of the converter conditions
    logic ramp_active, oc_eff, pg_eff;
    assign ramp_active = dynamic_voltage_ramp_in;
    assign oc_eff = cond_f.overcurrent & ~(ramp_active & ramp_ignore_ff);
    always_comb begin
        pg_eff = cond_f.power_good;
        if (ramp_active) begin
            case (pg_override_ff)
                pss_pkg::PG_OVR_BAD: pg_eff = 1'b0;
                pss_pkg::PG_OVR_GOOD: pg_eff = 1'b1;
                default: pg_eff = cond_f.power_good;
            endcase
        end
    end

    logic [1:0] therm_now;
    logic [3:0] conv_now;
    assign therm_now = {cond_f.thermal_shutdown, cond_f.thermal_warning};
    assign conv_now = {pg_eff, cond_f.overvoltage, cond_f.undervoltage, oc_eff};

    // Previous levels for edge detection; power-good events on its loss
    logic [1:0] therm_prev_ff;
    logic [3:0] conv_prev_ff;
    logic [2:0] pin_prev_ff;
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            therm_prev_ff <= '0;
            conv_prev_ff <= '0;
            pin_prev_ff <= '0;
        end else begin
            therm_prev_ff <= therm_now;
            conv_prev_ff <= conv_now;
            pin_prev_ff <= pin_f;
        end
    end

    // Over-current latch-off timer: the condition must persist without a break
    logic [CNT_W-1:0] oc_cnt_ff;
    logic [CNT_W-1:0] oc_limit;
    logic latchoff_fire;
    always_comb begin
        case (shutdown_delay_ff)
            2'h1: oc_limit = CNT_W'(pss_pkg::LATCHOFF_SHORT_CYC);
            2'h2: oc_limit = CNT_W'(LATCHOFF_MID_CYCLES);
            2'h3: oc_limit = CNT_W'(LATCHOFF_LONG_CYCLES);
            default: oc_limit = '0;
        endcase
    end
    assign latchoff_fire = shutdown_delay_ff != 2'h0 && oc_eff && !converter_shutdown_out
        && oc_cnt_ff == oc_limit - CNT_W'(1);

    always_ff @(posedge clock_in) begin
        if (srst_in || !oc_eff || shutdown_delay_ff == 2'h0) begin
            oc_cnt_ff <= '0;
        end else if (oc_cnt_ff != oc_limit) begin
            oc_cnt_ff <= oc_cnt_ff + CNT_W'(1);
        end
    end

    // Shutdown stays latched until reset or latch-off is disabled
    always_ff @(posedge clock_in) begin
        if (srst_in || shutdown_delay_ff == 2'h0) begin
            converter_shutdown_out <= 1'b0;
        end else if (latchoff_fire) begin
            converter_shutdown_out <= 1'b1;
        end
    end

    // Sticky update: a new event wins over a clear in the same cycle
    function automatic logic [3:0] evt_next(input logic [3:0] cur, input logic [3:0] set,
                                            input logic [3:0] clr, input logic [3:0] busy);
        evt_next = (cur & ~(clr & ~busy)) | set;
    endfunction

    logic [1:0] therm_set;
    logic [3:0] conv_set, conv_busy;
    logic [2:0] pin_set;
    assign therm_set = therm_now & ~therm_prev_ff;
    assign conv_set = {~conv_now[3] & conv_prev_ff[3], conv_now[2:0] & ~conv_prev_ff[2:0]}
        | {3'h0, latchoff_fire};
    assign conv_busy = {~conv_now[3], conv_now[2:0]};
    assign pin_set = pin_f ^ pin_prev_ff;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            therm_evt_ff <= '0;
        end else begin
            therm_evt_ff <= 2'(evt_next({2'h0, therm_evt_ff}, {2'h0, therm_set},
                {2'h0, wr_hit_therm_evt ? req_in.wdata[1:0] : 2'h0},
                {2'h0, therm_now}));
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            conv_evt_ff <= '0;
        end else begin
            conv_evt_ff <= evt_next(conv_evt_ff, conv_set,
                wr_hit_conv_evt ? req_in.wdata[3:0] : 4'h0, conv_busy);
        end
    end

    // Pin edges leave no lasting source, so a clear always takes effect
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            pin_evt_ff <= '0;
        end else begin
            pin_evt_ff <= 3'(evt_next({1'b0, pin_evt_ff}, {1'b0, pin_set},
                {1'b0, wr_hit_pin_evt ? req_in.wdata[2:0] : 3'h0}, 4'h0));
        end
    end

    // Mask registers; strap is caught in the first cycle after reset release
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            therm_mask_ff <= pss_pkg::RST_MASKS[1:0];
            conv_mask_ff <= pss_pkg::RST_MASKS[3:0];
            pin_mask_ff <= pss_pkg::RST_MASKS[2:0];
            lvl_therm_mask_ff <= pss_pkg::RST_MASKS[pss_pkg::LVL_THERMAL_BIT];
            lvl_pg_mask_ff <= pss_pkg::RST_MASKS[pss_pkg::LVL_POWER_GOOD_BIT];
            strap_done_ff <= 1'b0;
        end else begin
            strap_done_ff <= 1'b1;
            if (!strap_done_ff && strap_load_enable_in) begin
                lvl_therm_mask_ff <= strap_pin_in[1];
                lvl_pg_mask_ff <= strap_pin_in[0];
            end else if (req_in.wr) begin
                case (req_in.addr)
                    pss_pkg::ADDR_THERMAL_IRQ_MASKS: therm_mask_ff <= req_in.wdata[1:0];
                    pss_pkg::ADDR_CONVERTER_IRQ_MASKS: conv_mask_ff <= req_in.wdata[3:0];
                    pss_pkg::ADDR_PIN_IRQ_MASKS: pin_mask_ff <= req_in.wdata[2:0];
                    pss_pkg::ADDR_STATUS_LEVEL_IRQ_MASKS: begin
                        lvl_therm_mask_ff <= req_in.wdata[pss_pkg::LVL_THERMAL_BIT];
                        lvl_pg_mask_ff <= req_in.wdata[pss_pkg::LVL_POWER_GOOD_BIT];
                    end
                    default: ;
                endcase
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            shutdown_delay_ff <= pss_pkg::RST_PROTECTION_CONFIG[pss_pkg::SHUTDOWN_DELAY_LSB +: 2];
            ramp_ignore_ff <= pss_pkg::RST_PROTECTION_CONFIG[pss_pkg::RAMP_IGNORE_BIT];
            pg_override_ff <= pss_pkg::RST_PROTECTION_CONFIG[pss_pkg::PG_OVERRIDE_LSB +: 2];
            trim_ff <= pss_pkg::RST_OSC_BUS_CONFIG[pss_pkg::TRIM_LSB +: 3];
            bus_timeout_en_ff <= pss_pkg::RST_OSC_BUS_CONFIG[pss_pkg::BUS_TIMEOUT_EN_BIT];
            pin0_func_ff <= pss_pkg::RST_PIN0_FUNCTION_CONFIG[pss_pkg::PIN0_FUNC_LSB +: 4];
            pin0_drive_ff <= pss_pkg::RST_PIN0_FUNCTION_CONFIG[pss_pkg::PIN0_DRIVE_BIT];
        end else if (req_in.wr) begin
            case (req_in.addr)
                pss_pkg::ADDR_PROTECTION_CONFIG: begin
                    shutdown_delay_ff <= req_in.wdata[pss_pkg::SHUTDOWN_DELAY_LSB +: 2];
                    ramp_ignore_ff <= req_in.wdata[pss_pkg::RAMP_IGNORE_BIT];
                    pg_override_ff <= req_in.wdata[pss_pkg::PG_OVERRIDE_LSB +: 2];
                end
                pss_pkg::ADDR_OSC_BUS_CONFIG: begin
                    trim_ff <= req_in.wdata[pss_pkg::TRIM_LSB +: 3];
                    bus_timeout_en_ff <= req_in.wdata[pss_pkg::BUS_TIMEOUT_EN_BIT];
                end
                pss_pkg::ADDR_PIN0_FUNCTION_CONFIG: begin
                    pin0_func_ff <= req_in.wdata[pss_pkg::PIN0_FUNC_LSB +: 4];
                    pin0_drive_ff <= req_in.wdata[pss_pkg::PIN0_DRIVE_BIT];
                end
                default: ;
            endcase
        end
    end

    // Read data is registered; unmapped offsets and reserved bits read zero
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (req_in.rd) begin
            case (req_in.addr)
                pss_pkg::ADDR_THERMAL_STATUS: reg_rdata_out <= {6'h00, therm_now};
                pss_pkg::ADDR_CONVERTER_STATUS: reg_rdata_out <= {4'h0, conv_now};
                pss_pkg::ADDR_PIN_STATUS: reg_rdata_out <= {5'h00, pin_f};
                pss_pkg::ADDR_THERMAL_EVENTS: reg_rdata_out <= {6'h00, therm_evt_ff};
                pss_pkg::ADDR_CONVERTER_EVENTS: reg_rdata_out <= {4'h0, conv_evt_ff};
                pss_pkg::ADDR_PIN_EVENTS: reg_rdata_out <= {5'h00, pin_evt_ff};
                pss_pkg::ADDR_THERMAL_IRQ_MASKS: reg_rdata_out <= {6'h00, therm_mask_ff};
                pss_pkg::ADDR_CONVERTER_IRQ_MASKS: reg_rdata_out <= {4'h0, conv_mask_ff};
                pss_pkg::ADDR_PIN_IRQ_MASKS: reg_rdata_out <= {5'h00, pin_mask_ff};
                pss_pkg::ADDR_STATUS_LEVEL_IRQ_MASKS:
                    reg_rdata_out <= {4'h0, lvl_therm_mask_ff, 2'h0, lvl_pg_mask_ff};
                pss_pkg::ADDR_PROTECTION_CONFIG:
                    reg_rdata_out <= {1'b0, shutdown_delay_ff, ramp_ignore_ff,
                        pg_override_ff, 2'h0};
                pss_pkg::ADDR_OSC_BUS_CONFIG:
                    reg_rdata_out <= {1'b0, trim_ff, 2'h0, bus_timeout_en_ff, 1'b0};
                pss_pkg::ADDR_PIN0_FUNCTION_CONFIG:
                    reg_rdata_out <= {3'h0, pin0_func_ff, pin0_drive_ff};
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // Interrupt: unmasked latched events plus the two status-level sources
    logic irq_next;
    assign irq_next = |(therm_evt_ff & ~therm_mask_ff)
        | |(conv_evt_ff & ~conv_mask_ff)
        | |(pin_evt_ff & ~pin_mask_ff)
        | (cond_f.thermal_warning & ~lvl_therm_mask_ff)
        | (~pg_eff & ~lvl_pg_mask_ff);

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            interrupt_out <= 1'b0;
        end else begin
            interrupt_out <= irq_next;
        end
    end

    // Oscillator trim; the shift is trim times the step, signed
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            oscillator_trim_out <= '0;
            oscillator_shift_khz_out <= '0;
        end else begin
            oscillator_trim_out <= $signed(trim_ff);
            oscillator_shift_khz_out <= 11'($signed(trim_ff)
                * $signed(11'(pss_pkg::TRIM_STEP_KHZ)));
        end
    end

    // Stuck-low watch on the data line; one reset pulse per stuck episode
    logic [CNT_W-1:0] sda_cnt_ff;
    always_ff @(posedge clock_in) begin
        if (srst_in || sda_f || !bus_timeout_en_ff) begin
            sda_cnt_ff <= '0;
            serial_reset_out <= 1'b0;
        end else begin
            serial_reset_out <= sda_cnt_ff == CNT_W'(BUS_STUCK_CYCLES);
            if (sda_cnt_ff <= CNT_W'(BUS_STUCK_CYCLES)) begin
                sda_cnt_ff <= sda_cnt_ff + CNT_W'(1);
            end
        end
    end

    // Pin zero function; reserved codes behave as disabled
    logic pin0_level, pin0_drives;
    always_comb begin
        pin0_level = 1'b0;
        pin0_drives = 1'b1;
        case (pin0_func_ff)
            pss_pkg::PIN_FN_PG_OUT: pin0_level = pg_eff;
            pss_pkg::PIN_FN_IRQ_OUT: pin0_level = ~irq_next;
            pss_pkg::PIN_FN_LOW_OUT: pin0_level = 1'b0;
            pss_pkg::PIN_FN_HIGH_OUT: pin0_level = 1'b1;
            default: pin0_drives = 1'b0;
        endcase
    end

    // Open-drain only pulls low, so a high level releases the pin
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            pin0_out <= 1'b0;
            pin0_oe_out <= 1'b0;
        end else if (pin0_drive_ff) begin
            pin0_out <= pin0_level;
            pin0_oe_out <= pin0_drives;
        end else begin
            pin0_out <= 1'b0;
            pin0_oe_out <= pin0_drives & ~pin0_level;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            converter_enable_input_out <= 1'b0;
            voltage_select_input_out <= 1'b0;
            reload_input_out <= 1'b0;
        end else begin
            converter_enable_input_out <= pin0_func_ff == pss_pkg::PIN_FN_ENABLE_IN
                && pin_f[0];
            voltage_select_input_out <= pin0_func_ff == pss_pkg::PIN_FN_VSEL_IN && pin_f[0];
            reload_input_out <= pin0_func_ff == pss_pkg::PIN_FN_RELOAD_IN && pin_f[0];
        end
    end
endmodule

// ---- rtl/pss_pkg.sv ----
// Package for the system supervision register block: offsets, fields, resets and timings
package pss_pkg;
    // Register offsets on the serial interface register port
    localparam logic [7:0] ADDR_THERMAL_STATUS = 8'h01;
    localparam logic [7:0] ADDR_CONVERTER_STATUS = 8'h02;
    localparam logic [7:0] ADDR_PIN_STATUS = 8'h03;
    localparam logic [7:0] ADDR_THERMAL_EVENTS = 8'h04;
    localparam logic [7:0] ADDR_CONVERTER_EVENTS = 8'h05;
    localparam logic [7:0] ADDR_PIN_EVENTS = 8'h06;
    localparam logic [7:0] ADDR_THERMAL_IRQ_MASKS = 8'h07;
    localparam logic [7:0] ADDR_CONVERTER_IRQ_MASKS = 8'h08;
    localparam logic [7:0] ADDR_PIN_IRQ_MASKS = 8'h09;
    localparam logic [7:0] ADDR_STATUS_LEVEL_IRQ_MASKS = 8'h0a;
    localparam logic [7:0] ADDR_PROTECTION_CONFIG = 8'h0d;
    localparam logic [7:0] ADDR_OSC_BUS_CONFIG = 8'h0e;
    localparam logic [7:0] ADDR_PIN0_FUNCTION_CONFIG = 8'h10;

    // Field positions
    localparam int LVL_THERMAL_BIT = 3;
    localparam int LVL_POWER_GOOD_BIT = 0;
    localparam int SHUTDOWN_DELAY_LSB = 5;
    localparam int RAMP_IGNORE_BIT = 4;
    localparam int PG_OVERRIDE_LSB = 2;
    localparam int TRIM_LSB = 4;
    localparam int BUS_TIMEOUT_EN_BIT = 1;
    localparam int PIN0_FUNC_LSB = 1;
    localparam int PIN0_DRIVE_BIT = 0;

    // Reset values
    localparam logic [7:0] RST_MASKS = 8'h00;
    localparam logic [7:0] RST_PROTECTION_CONFIG = 8'h00;
    localparam logic [7:0] RST_OSC_BUS_CONFIG = 8'h00;
    localparam logic [7:0] RST_PIN0_FUNCTION_CONFIG = 8'h00;

    // Timing: figures in ns except the trim step in kHz, counts rounded up at the 50 ns clock
    localparam int CLK_PERIOD_NS = 50;
    localparam int LATCHOFF_SHORT_NS = 8000;
    localparam int LATCHOFF_MID_NS = 1000000;
    localparam int LATCHOFF_LONG_NS = 3000000;
    localparam int BUS_STUCK_NS = 50000000;
    localparam int LATCHOFF_SHORT_CYC = (LATCHOFF_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LATCHOFF_MID_CYC = (LATCHOFF_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LATCHOFF_LONG_CYC = (LATCHOFF_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUS_STUCK_CYC = (BUS_STUCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRIM_STEP_KHZ = 160;

    // Pin zero function codes
    typedef enum logic [3:0] {
        PIN_FN_DISABLED = 4'h0,
        PIN_FN_ENABLE_IN = 4'h1,
        PIN_FN_VSEL_IN = 4'h4,
        PIN_FN_RELOAD_IN = 4'h7,
        PIN_FN_PG_OUT = 4'h8,
        PIN_FN_IRQ_OUT = 4'hc,
        PIN_FN_LOW_OUT = 4'he,
        PIN_FN_HIGH_OUT = 4'hf
    } pss_pin_fn_e;

    // Power-good override during a ramp
    localparam logic [1:0] PG_OVR_NONE = 2'h0;
    localparam logic [1:0] PG_OVR_BAD = 2'h1;
    localparam logic [1:0] PG_OVR_GOOD = 2'h2;

    // Live supervision conditions
    typedef struct packed {
        logic thermal_shutdown;
        logic thermal_warning;
        logic power_good;
        logic overvoltage;
        logic undervoltage;
        logic overcurrent;
    } pss_cond_s;

    // Register port request from the serial interface engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pss_req_s;
endpackage

// ---- tb/pss_host_model.sv ----
// Host side of the register port: single-byte reads and writes
`timescale 1ns/100ps
module pss_host_model (
    input wire logic clock_in,
    output pss_pkg::pss_req_s req_out,
    input wire logic [7:0] rdata_in
);
    initial req_out = '0;
    // Request held over one full cycle so exactly one edge takes it
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge clock_in);
        #1 req_out = '{wr: w, rd: ~w, addr: a, wdata: d};
        @(posedge clock_in);
        #1 req_out = '0;
        @(posedge clock_in);
        #1 q = rdata_in;
    endtask
endmodule

// ---- tb/pss_supervision_asserts.sv ----
// Port checker for the supervision register block
`timescale 1ns/100ps
module pss_supervision_asserts #(
    parameter int LATCHOFF_MID_CYCLES = 20,
    parameter int LATCHOFF_LONG_CYCLES = 40,
    parameter int BUS_STUCK_CYCLES = 50,
    parameter int CNT_W = 21
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire pss_pkg::pss_cond_s cond_in,
    input wire logic sda_in,
    input wire pss_pkg::pss_req_s req_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic converter_shutdown_out,
    input wire logic serial_reset_out,
    input wire logic signed [2:0] oscillator_trim_out,
    input wire logic signed [10:0] oscillator_shift_khz_out,
    input wire logic pin0_out,
    input wire logic pin0_oe_out,
    input wire logic converter_enable_input_out,
    input wire logic voltage_select_input_out,
    input wire logic reload_input_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    property p_thermal_fields;
        req_in.rd && req_in.addr == pss_pkg::ADDR_THERMAL_STATUS |=> reg_rdata_out[7:2] == 6'h00;
    endproperty
    a_thermal_fields: assert property (p_thermal_fields) else $error("status spare set");
    property p_pin_fields;
        req_in.rd && req_in.addr == pss_pkg::ADDR_PIN_STATUS |=> reg_rdata_out[7:3] == 5'h00;
    endproperty
    a_pin_fields: assert property (p_pin_fields) else $error("pin spare bits set");
    property p_trim_shift;
        oscillator_shift_khz_out == oscillator_trim_out * 11'sd160;
    endproperty
    a_trim_shift: assert property (p_trim_shift) else $error("shift not trim * step");
    property p_serial_pulse;
        serial_reset_out |=> !serial_reset_out;
    endproperty
    a_serial_pulse: assert property (p_serial_pulse) else $error("serial reset long");
    property p_serial_cause;
        serial_reset_out |-> $past(sda_in, 8) == 1'b0;
    endproperty
    a_serial_cause: assert property (p_serial_cause) else $error("serial reset early");
    property p_input_roles;
        (converter_enable_input_out || voltage_select_input_out || reload_input_out) |->
            !pin0_oe_out && $onehot({converter_enable_input_out, voltage_select_input_out,
            reload_input_out});
    endproperty
    a_input_roles: assert property (p_input_roles) else $error("input role clash");
    property p_drive_high;
        pin0_out |-> pin0_oe_out;
    endproperty
    a_drive_high: assert property (p_drive_high) else $error("high but not driven");
    property p_shutdown_cause;
        $rose(converter_shutdown_out) |-> $past(cond_in.overcurrent, 10);
    endproperty
    a_shutdown_cause: assert property (p_shutdown_cause) else $error("shutdown early");
endmodule
bind pss_supervision pss_supervision_asserts #(.LATCHOFF_MID_CYCLES(LATCHOFF_MID_CYCLES),
    .LATCHOFF_LONG_CYCLES(LATCHOFF_LONG_CYCLES), .BUS_STUCK_CYCLES(BUS_STUCK_CYCLES),
    .CNT_W(CNT_W)) chk (.clock_in(clock_in), .srst_in(srst_in), .cond_in(cond_in),
    .sda_in(sda_in), .req_in(req_in), .reg_rdata_out(reg_rdata_out),
    .converter_shutdown_out(converter_shutdown_out), .serial_reset_out(serial_reset_out),
    .oscillator_trim_out(oscillator_trim_out),
    .oscillator_shift_khz_out(oscillator_shift_khz_out), .pin0_out(pin0_out),
    .pin0_oe_out(pin0_oe_out), .converter_enable_input_out(converter_enable_input_out),
    .voltage_select_input_out(voltage_select_input_out), .reload_input_out(reload_input_out));

// ---- tb/pss_supervision_tb.sv ----
// Testbench for the supervision register block
`timescale 1ns/100ps
module pss_supervision_tb;
    logic clock_in, srst_in, sda, ramp, strap_en, irq, shut, sres, p0, p0oe, en_i, vs_i, rl_i;
    logic [2:0] pin;
    logic [1:0] strap;
    logic [7:0] rdata;
    logic signed [2:0] trim;
    logic signed [10:0] shift;
    pss_pkg::pss_cond_s cond;
    pss_pkg::pss_req_s req;
    int error_cnt = 0, checks_done = 0, pulses = 0;
    localparam logic [7:0] RA [6] = '{8'h07, 8'h08, 8'h09, 8'h0d, 8'h0e, 8'h10};
    localparam logic [7:0] RM [6] = '{8'h03, 8'h0f, 8'h07, 8'h7c, 8'h72, 8'h1f};
    localparam logic [7:0] FN [10] = '{1, 3, 9, 15, 17, 25, 29, 31, 30, 28};
    localparam logic [4:0] FX [10] = '{0, 4, 2, 1, 24, 24, 8, 24, 0, 8};
    localparam int LO [4] = '{200, 150, 10, 30};
    localparam int HI [4] = '{250, 180, 35, 55};
    // Short counts so latch-off and bus timeout fit the run
    pss_supervision #(.LATCHOFF_MID_CYCLES(20), .LATCHOFF_LONG_CYCLES(40),
        .BUS_STUCK_CYCLES(50)) uut (.clock_in(clock_in), .srst_in(srst_in), .cond_in(cond),
        .pin_in(pin), .sda_in(sda), .dynamic_voltage_ramp_in(ramp),
        .strap_load_enable_in(strap_en), .strap_pin_in(strap), .req_in(req),
        .reg_rdata_out(rdata), .interrupt_out(irq), .converter_shutdown_out(shut),
        .serial_reset_out(sres), .oscillator_trim_out(trim), .oscillator_shift_khz_out(shift),
        .pin0_out(p0), .pin0_oe_out(p0oe), .converter_enable_input_out(en_i),
        .voltage_select_input_out(vs_i), .reload_input_out(rl_i));
    pss_host_model host (.clock_in(clock_in), .req_out(req), .rdata_in(rdata));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        host.access(1'b1, a, d, x);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] x;
        host.access(1'b0, a, 8'h00, x);
        check(x, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic wrap_up;
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clock_in) if (sres === 1'b1) pulses++;
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    // Watchdog far beyond the expected run of about a thousand cycles
    initial begin
        #1000000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        {srst_in, sda, ramp, strap_en, strap, pin} = 9'h1b9;
        cond = 6'b001000;
        repeat (8) @(posedge clock_in);
        #1 srst_in = 1'b0;
        cyc(2);
        rdc(8'h0a, 8'h09);
        rdc(8'h0b, 8'h00);
        wr(8'h0a, 8'h00);
        for (int i = 0; i < 6; i++) begin
            rdc(RA[i], 8'h00);
            wr(RA[i], 8'hff);
            rdc(RA[i], RM[i]);
            wr(RA[i], 8'h00);
        end
        wr(8'h01, 8'hff);
        rdc(8'h01, 8'h00);
        for (int a = 4; a < 7; a++) wr(8'(a), 8'hff);
        rdc(8'h06, 8'h00);
        check(irq, 1'b0);
        cond = 6'b111110;
        pin = 3'b101;
        cyc(8);
        rdc(8'h01, 8'h03);
        rdc(8'h02, 8'h0e);
        rdc(8'h03, 8'h05);
        rdc(8'h04, 8'h03);
        rdc(8'h05, 8'h06);
        rdc(8'h06, 8'h04);
        check(irq, 1'b1);
        wr(8'h04, 8'hff);
        rdc(8'h04, 8'h03);
        for (int i = 0; i < 3; i++) wr(RA[i], RM[i]);
        wr(8'h0a, 8'h08);
        cyc(2);
        check(irq, 1'b0);
        rdc(8'h04, 8'h03);
        cond = 6'b001000;
        cyc(8);
        for (int a = 4; a < 7; a++) wr(8'(a), 8'hff);
        for (int a = 4; a < 7; a++) rdc(8'(a), 8'h00);
        for (int a = 7; a < 11; a++) wr(8'(a), 8'h00);
        cond.power_good = 1'b0;
        cyc(8);
        wr(8'h08, 8'h08);
        cyc(2);
        check(irq, 1'b1);
        wr(8'h0a, 8'h01);
        cyc(2);
        check(irq, 1'b0);
        cond.power_good = 1'b1;
        cyc(8);
        wr(8'h05, 8'hff);
        wr(8'h08, 8'h00);
        wr(8'h0a, 8'h00);
        cyc(2);
        for (int i = 0; i < 10; i++) begin
            wr(8'h10, FN[i]);
            cyc(6);
            check({p0, p0oe, en_i, vs_i, rl_i}, FX[i]);
        end
        for (int i = 0; i < 4; i++) begin
            wr(8'h0d, 8'(i << 5));
            cond.overcurrent = 1'b1;
            cyc(LO[i]);
            check(shut, 1'b0);
            cyc(HI[i] - LO[i]);
            check(shut, i != 0);
            check(irq, 1'b1);
            wr(8'h0d, 8'h00);
            cond.overcurrent = 1'b0;
            cyc(6);
            wr(8'h05, 8'hff);
        end
        ramp = 1'b1;
        wr(8'h0d, 8'h50);
        cond.overcurrent = 1'b1;
        cyc(60);
        check(shut, 1'b0);
        rdc(8'h02, 8'h08);
        rdc(8'h05, 8'h00);
        cond.overcurrent = 1'b0;
        wr(8'h0d, 8'h04);
        rdc(8'h02, 8'h00);
        cond.power_good = 1'b0;
        wr(8'h0d, 8'h08);
        cyc(6);
        rdc(8'h02, 8'h08);
        ramp = 1'b0;
        for (int t = -4; t < 4; t++) begin
            wr(8'h0e, {1'b0, 3'(t), 4'h0});
            check(32'(shift), 32'(t * 160));
            check(32'(trim), 32'(t));
        end
        wr(8'h0e, 8'h02);
        pulses = 0;
        sda = 1'b0;
        cyc(80);
        sda = 1'b1;
        cyc(6);
        check(pulses, 1);
        wrap_up();
    end
endmodule
